// >>> design/udc_pkg.sv
package udc_pkg;

	// register byte offsets
	localparam logic [7:0] OFS_OPA_LO = 8'h00;
	localparam logic [7:0] OFS_OPA_HI = 8'h04;
	localparam logic [7:0] OFS_OPB_LO = 8'h08;
	localparam logic [7:0] OFS_OPB_HI = 8'h0C;
	localparam logic [7:0] OFS_IMM = 8'h10;
	localparam logic [7:0] OFS_CMD = 8'h14;
	localparam logic [7:0] OFS_DEST_LO = 8'h18;
	localparam logic [7:0] OFS_DEST_HI = 8'h1C;
	localparam logic [7:0] OFS_COND = 8'h20;
	localparam logic [7:0] OFS_FXER = 8'h24;
	localparam logic [7:0] OFS_STATUS = 8'h28;

	// field positions
	localparam int CMD_W = 9;
	localparam int IMM_W = 16;
	localparam int FXER_SO = 31;
	localparam int FXER_OV = 30;
	localparam logic [31:0] FXER_MASK = 32'hE000_0000;
	localparam int STAT_BUSY = 0;
	localparam int STAT_INVALID = 1;
	localparam logic [2:0] FLD_LAST = 3'h7;

	// reset values
	localparam logic [63:0] RST_WORD64 = 64'h0000_0000_0000_0000;
	localparam logic [31:0] RST_WORD32 = 32'h0000_0000;
	localparam logic [31:0] ZERO32 = 32'h0000_0000;
	localparam logic [47:0] ZERO48 = 48'h0000_0000_0000;

	// timing
	localparam logic [6:0] DIV_STEPS = 7'h40;

	typedef enum logic [2:0] {
		OP_DIVWU,
		OP_DIVDU,
		OP_SUBF,
		OP_CMPI,
		OP_CMP,
		OP_CMPLI,
		OP_CMPL
	} udc_op_e;

	typedef struct packed {
		logic [2:0] fld;
		logic len;
		logic ovf;
		logic rec;
		udc_op_e op;
	} udc_cmd_s;

	typedef struct packed {
		logic lt;
		logic gt;
		logic eq;
	} udc_cmp_s;

	// write one 4-bit field, field 0 leftmost
	function automatic logic [31:0] udc_put_field(logic [31:0] cr,
		logic [2:0] fld, logic [3:0] nib);
		logic [31:0] r;
		r = cr;
		r[(FLD_LAST - fld) * 4 +: 4] = nib;
		return r;
	endfunction

endpackage

// >>> design/udc_divider.sv
`timescale 1ns/10ps
module udc_divider (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// request
	input wire logic start,
	input wire logic [63:0] dividend,
	input wire logic [63:0] divisor,
	// result
	output logic busy,
	output logic done,
	output logic [63:0] quotient
);

	logic [63:0] rem, next_rem;
	logic [63:0] quo, next_quo;
	logic [63:0] dvs, next_dvs;
	logic [6:0] cnt, next_cnt;
	logic done_q, next_done;

	// one restoring step per clock
	always_comb begin
		logic [64:0] trial;
		logic [64:0] diff;
		trial = {rem, quo[63]};
		diff = trial - {1'b0, dvs};
		next_rem = rem;
		next_quo = quo;
		next_dvs = dvs;
		next_cnt = cnt;
		next_done = 1'b0;
		if (start) begin
			next_rem = udc_pkg::RST_WORD64;
			next_quo = dividend;
			next_dvs = divisor;
			next_cnt = udc_pkg::DIV_STEPS;
		end else if (cnt != 7'h00) begin
			if (trial >= {1'b0, dvs}) begin
				next_rem = diff[63:0];
				next_quo = {quo[62:0], 1'b1};
			end else begin
				next_rem = trial[63:0];
				next_quo = {quo[62:0], 1'b0};
			end
			next_cnt = cnt - 7'h01;
			next_done = (cnt == 7'h01);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rem <= 64'h0000_0000_0000_0000;
			quo <= 64'h0000_0000_0000_0000;
			dvs <= 64'h0000_0000_0000_0000;
			cnt <= 7'h00;
			done_q <= 1'b0;
		end else begin
			rem <= next_rem;
			quo <= next_quo;
			dvs <= next_dvs;
			cnt <= next_cnt;
			done_q <= next_done;
		end
	end

	assign busy = (cnt != 7'h00);
	assign done = done_q;
	// quotient only; remainder never leaves
	assign quotient = quo;

endmodule

// >>> design/udc_compare.sv
`timescale 1ns/10ps
module udc_compare (
	// operands
	input wire logic [63:0] a,
	input wire logic [63:0] b,
	// mode
	input wire logic signed_cmp,
	input wire logic len64,
	// outcome
	output udc_pkg::udc_cmp_s res
);

	// low word, extended by its sign bit (bit 32 big-endian) when sgn, else by zeros
	function automatic logic [63:0] udc_narrow(logic [63:0] v, logic sgn);
		return sgn ? {{32{v[31]}}, v[31:0]} : {udc_pkg::ZERO32, v[31:0]};
	endfunction

	always_comb begin
		logic [63:0] ae;
		logic [63:0] be;
		ae = len64 ? a : udc_narrow(a, signed_cmp);
		be = len64 ? b : udc_narrow(b, signed_cmp);
		res.eq = (ae == be);
		if (signed_cmp) begin
			res.lt = ($signed(ae) < $signed(be));
		end else begin
			res.lt = (ae < be);
		end
		res.gt = !res.lt && !res.eq;
	end

endmodule

// >>> design/udc_core.sv
`timescale 1ns/10ps
module udc_core #(
	parameter bit IMPL_64 = 1'b1
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr
);

	// operand registers
	logic [63:0] opa, next_opa;
	logic [63:0] opb, next_opb;
	logic [15:0] imm, next_imm;
	// execution state
	udc_pkg::udc_cmd_s cmd_q, next_cmd;
	logic busy, next_busy;
	logic invalid, next_invalid;
	logic [63:0] dest, next_dest;
	logic [31:0] cond, next_cond;
	logic [31:0] fxer, next_fxer;
	logic [31:0] next_prdata;

	logic wr, rd_setup, go, bad, is_div, is_cmp, div_done, div_busy;
	logic signed_cmp, div_zero;
	udc_pkg::udc_cmd_s cmd_w;
	logic [63:0] cmp_b, diff, quot, dvd, dvs;
	udc_pkg::udc_cmp_s cmp_res;

	function automatic logic reg_known(logic [7:0] a);
		case (a)
			udc_pkg::OFS_OPA_LO, udc_pkg::OFS_OPA_HI,
			udc_pkg::OFS_OPB_LO, udc_pkg::OFS_OPB_HI,
			udc_pkg::OFS_IMM, udc_pkg::OFS_CMD,
			udc_pkg::OFS_DEST_LO, udc_pkg::OFS_DEST_HI,
			udc_pkg::OFS_COND, udc_pkg::OFS_FXER,
			udc_pkg::OFS_STATUS: return 1'b1;
			default: return 1'b0;
		endcase
	endfunction

	function automatic logic op_is_cmp(udc_pkg::udc_op_e op);
		return op == udc_pkg::OP_CMPI || op == udc_pkg::OP_CMP ||
			op == udc_pkg::OP_CMPLI || op == udc_pkg::OP_CMPL;
	endfunction

	// apb decode
	assign wr = psel && penable && pwrite && reg_known(paddr);
	assign rd_setup = psel && !penable && !pwrite;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !reg_known(paddr);

	// command launch
	assign cmd_w = udc_pkg::udc_cmd_s'(pwdata[udc_pkg::CMD_W-1:0]);
	assign go = wr && (paddr == udc_pkg::OFS_CMD) && !busy;
	assign is_cmp = op_is_cmp(cmd_w.op);
	assign is_div = cmd_w.op == udc_pkg::OP_DIVWU ||
		cmd_w.op == udc_pkg::OP_DIVDU;
	assign bad = (cmd_w.op > udc_pkg::OP_CMPL) ||
		(!IMPL_64 && cmd_w.op == udc_pkg::OP_DIVDU) ||
		(!IMPL_64 && is_cmp && cmd_w.len);
	assign signed_cmp = cmd_w.op == udc_pkg::OP_CMPI ||
		cmd_w.op == udc_pkg::OP_CMP;

	// second compare operand
	always_comb begin
		case (cmd_w.op)
			udc_pkg::OP_CMPI: cmp_b = {{48{imm[15]}}, imm};
			udc_pkg::OP_CMPLI: cmp_b = {udc_pkg::ZERO48, imm};
			default: cmp_b = opb;
		endcase
	end

	udc_compare u_cmp (
		.a(opa),
		.b(cmp_b),
		.signed_cmp(signed_cmp),
		.len64(cmd_w.len && IMPL_64),
		.res(cmp_res)
	);

	assign diff = opb - opa;
	assign dvd = (cmd_w.op == udc_pkg::OP_DIVWU) ?
		{udc_pkg::ZERO32, opa[31:0]} : opa;
	assign dvs = (cmd_w.op == udc_pkg::OP_DIVWU) ?
		{udc_pkg::ZERO32, opb[31:0]} : opb;

	udc_divider u_div (
		.pclk(pclk),
		.presetn(presetn),
		.start(go && !bad && is_div),
		.dividend(dvd),
		.divisor(dvs),
		.busy(div_busy),
		.done(div_done),
		.quotient(quot)
	);

	// operands held stable while a divide runs
	assign div_zero = (cmd_q.op == udc_pkg::OP_DIVWU) ?
		(opb[31:0] == udc_pkg::ZERO32) : (opb == udc_pkg::RST_WORD64);

	// operand register group
	always_comb begin
		next_opa = opa;
		next_opb = opb;
		next_imm = imm;
		if (wr && !busy) begin
			case (paddr)
				udc_pkg::OFS_OPA_LO: next_opa[31:0] = pwdata;
				udc_pkg::OFS_OPA_HI: next_opa[63:32] = pwdata;
				udc_pkg::OFS_OPB_LO: next_opb[31:0] = pwdata;
				udc_pkg::OFS_OPB_HI: next_opb[63:32] = pwdata;
				udc_pkg::OFS_IMM: next_imm = pwdata[udc_pkg::IMM_W-1:0];
				default: next_imm = imm;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			opa <= 64'h0000_0000_0000_0000;
			opb <= 64'h0000_0000_0000_0000;
			imm <= 16'h0000;
		end else begin
			opa <= next_opa;
			opb <= next_opb;
			imm <= next_imm;
		end
	end

	// execution group
	always_comb begin
		logic [63:0] res;
		logic so;
		res = udc_pkg::RST_WORD64;
		so = 1'b0;
		next_cmd = cmd_q;
		next_busy = busy;
		next_invalid = invalid;
		next_dest = dest;
		next_cond = cond;
		next_fxer = fxer;
		if (go) begin
			next_cmd = cmd_w;
			next_invalid = bad;
			if (!bad) begin
				if (is_div) begin
					next_busy = 1'b1;
				end else if (cmd_w.op == udc_pkg::OP_SUBF) begin
					next_dest = diff;
				end else begin
					// lt, gt, eq, then summary overflow
					next_cond = udc_pkg::udc_put_field(cond, cmd_w.fld,
						{cmp_res.lt, cmp_res.gt, cmp_res.eq,
						fxer[udc_pkg::FXER_SO]});
				end
			end
		end else if (div_done) begin
			next_busy = 1'b0;
			if (cmd_q.op == udc_pkg::OP_DIVWU) begin
				next_dest = {udc_pkg::ZERO32, quot[31:0]};
				res = {{32{quot[31]}}, quot[31:0]};
			end else begin
				next_dest = quot;
				res = quot;
			end
			so = fxer[udc_pkg::FXER_SO];
			if (cmd_q.ovf) begin
				next_fxer[udc_pkg::FXER_OV] = div_zero;
				so = so || div_zero;
				next_fxer[udc_pkg::FXER_SO] = so;
			end
			if (cmd_q.rec) begin
				next_cond = udc_pkg::udc_put_field(cond, 3'h0,
					{res[63], !res[63] && res != udc_pkg::RST_WORD64,
					res == udc_pkg::RST_WORD64, so});
			end
		end else if (wr && !busy && paddr == udc_pkg::OFS_COND) begin
			next_cond = pwdata;
		end else if (wr && !busy && paddr == udc_pkg::OFS_FXER) begin
			next_fxer = pwdata & udc_pkg::FXER_MASK;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmd_q <= '0;
			busy <= 1'b0;
			invalid <= 1'b0;
			dest <= 64'h0000_0000_0000_0000;
			cond <= 32'h0000_0000;
			fxer <= 32'h0000_0000;
		end else begin
			cmd_q <= next_cmd;
			busy <= next_busy;
			invalid <= next_invalid;
			dest <= next_dest;
			cond <= next_cond;
			fxer <= next_fxer;
		end
	end

	// read data, captured in the setup phase
	always_comb begin
		next_prdata = prdata;
		if (rd_setup) begin
			case (paddr)
				udc_pkg::OFS_OPA_LO: next_prdata = opa[31:0];
				udc_pkg::OFS_OPA_HI: next_prdata = opa[63:32];
				udc_pkg::OFS_OPB_LO: next_prdata = opb[31:0];
				udc_pkg::OFS_OPB_HI: next_prdata = opb[63:32];
				udc_pkg::OFS_IMM: next_prdata = {16'h0000, imm};
				udc_pkg::OFS_CMD: next_prdata = {23'h00_0000, cmd_q};
				udc_pkg::OFS_DEST_LO: next_prdata = dest[31:0];
				udc_pkg::OFS_DEST_HI: next_prdata = dest[63:32];
				udc_pkg::OFS_COND: next_prdata = cond;
				udc_pkg::OFS_FXER: next_prdata = fxer;
				udc_pkg::OFS_STATUS: begin
					next_prdata = udc_pkg::RST_WORD32;
					next_prdata[udc_pkg::STAT_BUSY] = busy;
					next_prdata[udc_pkg::STAT_INVALID] = invalid;
				end
				default: next_prdata = udc_pkg::RST_WORD32;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else begin
			prdata <= next_prdata;
		end
	end

	// checks
	default clocking dflt_cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	a_subf_diff: assert property (
		go && !bad && cmd_w.op == udc_pkg::OP_SUBF
		|=> dest == $past(opb) - $past(opa))
		else $error("subtract-from result wrong");

	a_cmp_onehot: assert property (
		go && !bad && is_cmp
		|=> $onehot(cond[(udc_pkg::FLD_LAST - cmd_q.fld) * 4 + 1 +: 3]))
		else $error("compare field not one-hot");

	a_cmp_so_copy: assert property (
		go && !bad && is_cmp
		|=> cond[(udc_pkg::FLD_LAST - cmd_q.fld) * 4] ==
		$past(fxer[udc_pkg::FXER_SO]))
		else $error("summary overflow not copied");

	a_cmp_signed_word: assert property (
		go && !bad && cmd_w.op == udc_pkg::OP_CMP && !cmd_w.len
		|=> cond[(udc_pkg::FLD_LAST - cmd_q.fld) * 4 + 3] ==
		($signed($past(opa[31:0])) < $signed($past(opb[31:0]))))
		else $error("signed word compare wrong");

	a_cmpli_zext: assert property (
		go && !bad && cmd_w.op == udc_pkg::OP_CMPLI && cmd_w.len
		|=> cond[(udc_pkg::FLD_LAST - cmd_q.fld) * 4 + 3] ==
		($past(opa) < {udc_pkg::ZERO48, $past(imm)}))
		else $error("unsigned immediate compare wrong");

	a_plain_keeps_cr: assert property (
		div_done && !cmd_q.rec |=> $stable(cond))
		else $error("plain divide changed condition register");

	a_ovf_flag: assert property (
		div_done && cmd_q.ovf |=> fxer[udc_pkg::FXER_OV] == $past(div_zero))
		else $error("divide overflow flag wrong");

	a_div_word: assert property (
		div_done && cmd_q.op == udc_pkg::OP_DIVWU && !div_zero
		|=> dest[31:0] == opa[31:0] / opb[31:0])
		else $error("word divide quotient wrong");

	a_div_dword: assert property (
		div_done && cmd_q.op == udc_pkg::OP_DIVDU && !div_zero
		|=> dest == opa / opb)
		else $error("doubleword divide quotient wrong");

	a_bad_len: assert property (
		go && is_cmp && cmd_w.len && !IMPL_64
		|=> invalid && $stable(cond))
		else $error("long compare accepted on 32-bit part");

	a_div_busy_held: assert property (
		div_busy |-> busy)
		else $error("busy dropped while divider runs");

endmodule

// >>> tb/udc_core_tb_top.sv
`timescale 1ns/10ps
module udc_core_tb_top;
	logic pclk, presetn, psel, penable, pwrite, narrow, err;
	logic rdy_w, rdy_n, err_w, err_n;
	logic [7:0] paddr;
	logic [31:0] pwdata, prd_w, prd_n, rd, cond, fxer, d;
	logic [63:0] dst, a, b;
	logic [8:0] cmd;
	int n_errors = 0, n_tests = 0, seed, cyc = 0;

	udc_core #(.IMPL_64(1'b1)) udc_core_inst (.pclk(pclk), .presetn(presetn),
		.psel(psel && !narrow), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prd_w), .pready(rdy_w),
		.pslverr(err_w));
	udc_core #(.IMPL_64(1'b0)) udc_core_narrow_inst (.pclk(pclk),
		.presetn(presetn), .psel(psel && narrow), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prd_n),
		.pready(rdy_n), .pslverr(err_n));

	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end

	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			n_errors++;
			finish_test();
		end
	end

	task automatic finish_test;
		$display("checks %0d, mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_errors++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// one apb transfer, idle cycle before setup
	task automatic xfer(input logic w, input logic [7:0] ad,
		input logic [31:0] wd);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= ad;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while ((narrow ? rdy_n : rdy_w) !== 1'b1);
		rd = narrow ? prd_n : prd_w;
		err = narrow ? err_n : err_w;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// field nibble {lt, gt, eq, so}
	function automatic logic [3:0] nib(logic [63:0] x0, logic [63:0] y0,
		logic sg, logic ln, logic so);
		logic [63:0] x, y;
		x = ln ? x0 : {{32{sg & x0[31]}}, x0[31:0]};
		y = ln ? y0 : {{32{sg & y0[31]}}, y0[31:0]};
		if (sg) begin
			return {$signed(x) < $signed(y), $signed(x) > $signed(y), x == y, so};
		end
		return {x < y, x > y, x == y, so};
	endfunction

	function automatic logic [31:0] put(logic [31:0] c, logic [2:0] f,
		logic [3:0] v);
		return (c & ~(32'hF000_0000 >> 4 * f)) | ({v, 28'h0000_000} >> 4 * f);
	endfunction

	// load operands, launch, wait, compare results
	task automatic run(input logic [63:0] x, input logic [63:0] y,
		input logic [15:0] imm, input logic [8:0] c);
		logic [63:0] q, yy;
		logic [31:0] ec, ef;
		logic [2:0] op;
		logic inv, zd;
		op = c[2:0];
		xfer(1'b1, udc_pkg::OFS_OPA_LO, x[31:0]);
		xfer(1'b1, udc_pkg::OFS_OPA_HI, x[63:32]);
		xfer(1'b1, udc_pkg::OFS_OPB_LO, y[31:0]);
		xfer(1'b1, udc_pkg::OFS_OPB_HI, y[63:32]);
		xfer(1'b1, udc_pkg::OFS_IMM, {16'h0000, imm});
		xfer(1'b1, udc_pkg::OFS_CMD, {23'h00_0000, c});
		do begin
			xfer(1'b0, udc_pkg::OFS_STATUS, 32'h0000_0000);
		end while (rd[0] !== 1'b0);
		inv = op == 3'h7 || narrow && (op == 3'h1 || op > 3'h2 && c[5]);
		check(rd[1], inv);
		ec = cond;
		ef = fxer;
		if (!inv && op < 3'h2) begin
			zd = op[0] ? y == 64'h0 : y[31:0] == 32'h0000_0000;
			q = op[0] ? (zd ? '1 : x / y) :
				{32'h0000_0000, zd ? 32'hFFFF_FFFF : x[31:0] / y[31:0]};
			if (c[4]) begin
				ef[30] = zd;
				ef[31] = ef[31] | zd;
			end
			if (c[3]) begin
				yy = op[0] ? q : {{32{q[31]}}, q[31:0]};
				ec = put(ec, 3'h0, nib(yy, 64'h0, 1'b1, 1'b1, ef[31]));
			end
			dst = q;
		end else if (!inv && op == 3'h2) begin
			dst = y - x;
		end else if (!inv) begin
			yy = op == 3'h3 ? {{48{imm[15]}}, imm} :
				op == 3'h5 ? {48'h0000_0000_0000, imm} : y;
			ec = put(ec, c[8:6], nib(x, yy, op < 3'h5, c[5], fxer[31]));
		end
		xfer(1'b0, udc_pkg::OFS_DEST_LO, 32'h0000_0000);
		check(rd, dst[31:0]);
		xfer(1'b0, udc_pkg::OFS_DEST_HI, 32'h0000_0000);
		check(rd, dst[63:32]);
		xfer(1'b0, udc_pkg::OFS_COND, 32'h0000_0000);
		check(rd, ec);
		xfer(1'b0, udc_pkg::OFS_FXER, 32'h0000_0000);
		check(rd, ef);
		cond = ec;
		fxer = ef;
	endtask

	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		narrow = 1'b1;
		presetn = 1'b0;
		seed = 36;
		cond = 32'h0000_0000;
		fxer = 32'h0000_0000;
		dst = 64'h0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		// 32-bit part: long compares and doubleword divide refused
		run(64'h3, 64'h5, 16'h0000, 9'h0A4);
		run(64'h3, 64'h5, 16'h0000, 9'h0A6);
		run(64'h9, 64'h2, 16'h0000, 9'h001);
		run(64'h8000_0000, 64'h5, 16'h0000, 9'h086);
		run(64'h8000_0000, 64'h5, 16'h0000, 9'h0C4);
		$display("test narrow done, mismatches %0d", n_errors);
		narrow <= 1'b0;
		cond = 32'h0000_0000;
		fxer = 32'h0000_0000;
		dst = 64'h0;
		xfer(1'b0, udc_pkg::OFS_STATUS, 32'h0000_0000);
		check(rd, 32'h0000_0000);
		xfer(1'b1, 8'h40, 32'hA5A5_A5A5);
		check(err, 1'b1);
		xfer(1'b0, 8'hFC, 32'h0000_0000);
		check({err, rd}, {1'b1, 32'h0000_0000});
		$display("test registers done, mismatches %0d", n_errors);
		run(64'hFFFF_FFFF_0000_0064, 64'h7, 16'h0000, 9'h018);
		run(64'h5, 64'h1_0000_0000, 16'h0000, 9'h018);
		run(64'hFFFF_FFFF_FFFF_FFFF, 64'h3, 16'h0000, 9'h009);
		run(64'h1, 64'h0, 16'h0000, 9'h01A);
		run(64'h1_8000_0000, 64'h7FFF_FFFF, 16'h0000, 9'h1C4);
		run(64'h1_8000_0000, 64'h7FFF_FFFF, 16'h0000, 9'h0E4);
		run(64'hFFFF_FFFF_FFFF_FFFF, 64'h0, 16'hFFFF, 9'h063);
		run(64'hFFFF_FFFF_FFFF_FFFF, 64'h0, 16'hFFFF, 9'h025);
		run(64'h7, 64'h7, 16'h0000, 9'h007);
		$display("test corners done, mismatches %0d", n_errors);
		for (int k = 0; k < 100; k++) begin
			a = {$random(seed), $random(seed)};
			b = {$random(seed), $random(seed)};
			b = b >> ($unsigned($random(seed)) % 64);
			cmd = 9'($random(seed));
			if (k % 5 == 0) begin
				b = a;
			end
			if (k % 7 == 0) begin
				d = $random(seed);
				xfer(1'b1, udc_pkg::OFS_FXER, d);
				fxer = d & udc_pkg::FXER_MASK;
			end
			run(a, b, 16'($random(seed)), cmd);
		end
		$display("test random done, mismatches %0d", n_errors);
		finish_test();
	end
endmodule
